// ==== rtl/sarrd_top.sv ====
// Conversion and serial readout sequencer of the 12-bit differential converter.
`timescale 1ns/1ps
module sarrd_top
	import sarrd_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Serial link.
	input  wire logic        sel_n,
	input  wire logic        serial_shift_clock,
	output logic             dout_o,
	output logic             dout_oe,
	// Analog front end.
	input  wire logic        cmp_in,
	output logic             sample_en,
	output logic [11:0]      dac_code,
	output logic             conv_done,
	output logic [11:0]      result
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} sarrd_state_t;

	typedef struct packed {
		sarrd_state_t st;
		logic [4:0]   edges;
		logic [11:0]  sar;
		logic [11:0]  trial;
		logic [11:0]  res;
		logic         dout;
		logic         oe;
		logic         samp;
		logic         done;
		logic [1:0]   cmp_meta;
	} sarrd_st_t;

	sarrd_st_t s_r;
	sarrd_st_t s_nxt;

	sarrd_sync_if sy ();

	sarrd_sync u_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.sel_n_pin (sel_n),
		.sclk_pin  (serial_shift_clock),
		.sy        (sy)
	);

	// Index of the bit decided at a given falling edge, MSB first.
	function automatic logic [3:0] msb_idx(input logic [4:0] e);
		logic [4:0] d;
		d = EDGE_MSB_LAST - e;
		msb_idx = d[3:0];
	endfunction

	// Trial bit weight as a one-hot mask.
	function automatic logic [11:0] weight(input logic [3:0] i);
		weight = 12'h001 << i;
	endfunction

	logic [11:0] cur;
	logic [3:0]  bi;
	logic [4:0]  ne;

	always_comb
	begin
		s_nxt          = s_r;
		cur            = 12'h000;
		bi             = 4'h0;
		ne             = 5'h00;
		s_nxt.cmp_meta = {s_r.cmp_meta[0], cmp_in};
		s_nxt.done     = 1'b0;
		case (s_r.st)
			ST_IDLE:
			begin
				s_nxt.oe   = 1'b0;
				s_nxt.dout = 1'b0;
				if (sy.sel_fall)
				begin
					s_nxt.st    = ST_RUN;
					s_nxt.edges = 5'h00;
					s_nxt.samp  = 1'b1;
					s_nxt.sar   = 12'h000;
					s_nxt.trial = 12'h000;
				end
			end
			ST_RUN:
			begin
				if (sy.sel_high)
				begin
					// Early end of the cycle by the controller.
					s_nxt.st   = ST_IDLE;
					s_nxt.oe   = 1'b0;
					s_nxt.samp = 1'b0;
				end
				else if (sy.sclk_fall)
				begin
					ne          = s_r.edges + 5'h01;
					s_nxt.edges = ne;
					if (ne == EDGE_HOLD)
						s_nxt.samp = 1'b0;
					if (ne == EDGE_NULL)
					begin
						s_nxt.oe   = 1'b1;
						s_nxt.dout = 1'b0;
					end
					else if (ne > EDGE_NULL && ne <= EDGE_MSB_LAST)
					begin
						// Each falling edge decides one bit of the running conversion.
						bi          = msb_idx(ne);
						cur         = s_r.sar | weight(bi);
						// Sign bit is inverted so that the code is two's complement.
						if (bi == 4'(RES_BITS - 1))
							s_nxt.sar = cur ^ (s_r.cmp_meta[1] ? weight(bi) : 12'h000);
						else
							s_nxt.sar = s_r.cmp_meta[1] ? cur : s_r.sar;
						s_nxt.dout = s_nxt.sar[bi];
						if (ne == EDGE_MSB_LAST)
						begin
							s_nxt.res  = s_nxt.sar;
							s_nxt.done = 1'b1;
						end
					end
					else if (ne > EDGE_MSB_LAST && ne <= EDGE_LSB_LAST)
					begin
						bi         = 4'(ne - EDGE_MSB_LAST);
						s_nxt.dout = s_r.res[bi];
					end
					else if (ne >= EDGE_TRI)
					begin
						s_nxt.oe    = 1'b0;
						s_nxt.dout  = 1'b0;
						s_nxt.st    = ST_DONE;
					end
				end
				s_nxt.trial = (s_nxt.edges > EDGE_NULL && s_nxt.edges < EDGE_MSB_LAST)
					? (s_nxt.sar | weight(msb_idx(s_nxt.edges + 5'h01))) : s_nxt.sar;
			end
			ST_DONE:
			begin
				s_nxt.oe = 1'b0;
				if (sy.sel_high)
					s_nxt.st = ST_IDLE;
			end
			default:
				s_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '{st: ST_IDLE, edges: 5'h00, sar: 12'h000, trial: 12'h000, res: 12'h000,
				dout: 1'b0, oe: 1'b0, samp: 1'b0, done: 1'b0, cmp_meta: 2'h0};
		else
			s_r <= s_nxt;
	end

	assign dout_o    = s_r.dout;
	assign dout_oe   = s_r.oe;
	assign sample_en = s_r.samp;
	assign dac_code  = s_r.trial;
	assign conv_done = s_r.done;
	assign result    = s_r.res;

	property p_null_bit;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && sy.sclk_fall && !sy.sel_high && s_r.edges == 5'h01) |=> (dout_oe && !dout_o);
	endproperty
	a_null_bit: assert property (p_null_bit) else $error("null bit not driven low");

	property p_tri_after;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_DONE) |-> !dout_oe;
	endproperty
	a_tri_after: assert property (p_tri_after) else $error("output driven after readout");

	property p_idle_quiet;
		@(posedge clk) disable iff (!rst_n)
		dout_oe |-> (s_r.st == ST_RUN && s_r.edges >= EDGE_NULL && s_r.edges <= EDGE_LSB_LAST);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("output enabled outside the readout");

	property p_sample_start;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_IDLE && sy.sel_fall) |=> sample_en;
	endproperty
	a_sample_start: assert property (p_sample_start) else $error("sampling not started");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && s_r.edges >= EDGE_HOLD) |-> !sample_en;
	endproperty
	a_hold: assert property (p_hold) else $error("inputs not isolated");

	property p_lsb_repeat;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && !sy.sel_high && sy.sclk_fall && s_r.edges == EDGE_MSB_LAST)
			|=> (dout_o == s_r.res[1]);
	endproperty
	a_lsb_repeat: assert property (p_lsb_repeat) else $error("LSB-first repeat wrong");

	property p_msb_repeat;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && s_r.edges == EDGE_LSB_LAST && dout_oe) |-> (dout_o == s_r.res[11]);
	endproperty
	a_msb_repeat: assert property (p_msb_repeat) else $error("MSB not repeated last");

	property p_msb_first;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && s_r.edges > EDGE_NULL && s_r.edges <= EDGE_MSB_LAST)
			|-> (dout_o == s_r.sar[msb_idx(s_r.edges)]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("MSB-first bit mismatch");

	property p_done_result;
		@(posedge clk) disable iff (!rst_n)
		conv_done |-> (result == s_r.sar && dout_o == result[0]);
	endproperty
	a_done_result: assert property (p_done_result) else $error("result not the current conversion");
endmodule

// ==== rtl/sarrd_pkg.sv ====
// Shared constants for the serial readout of the converter.
package sarrd_pkg;
	localparam int unsigned RES_BITS      = 12;
	localparam int unsigned CNT_W         = 5;
	// Falling shift-clock edges counted from select falling.
	localparam logic [4:0]  EDGE_NULL     = 5'h02;
	localparam logic [4:0]  EDGE_MSB_LAST = 5'h0e;
	localparam logic [4:0]  EDGE_LSB_LAST = 5'h19;
	localparam logic [4:0]  EDGE_TRI      = 5'h1a;
	// Sampling phase end in falling edges, 1.5 clocks rounded to the edge after.
	localparam logic [4:0]  EDGE_HOLD     = 5'h02;
	localparam logic [11:0] CODE_POS_FS   = 12'h7ff;
	localparam logic [11:0] CODE_NEG_FS   = 12'h800;
	localparam logic [11:0] CODE_ZERO     = 12'h000;
	localparam logic [11:0] CODE_MINUS1   = 12'hfff;
	localparam int unsigned CLK_HZ        = 10000000;
	localparam int unsigned SCLK_MAX_HZ   = 3200000;
	localparam int unsigned SCLK_MIN_HZ   = 10000;
	localparam int unsigned CLKS_PER_CONV = 16;
endpackage

// ==== rtl/sarrd_sync_if.sv ====
// Synchronised select level and select and shift-clock edge pulses passed from the synchroniser to the sequencer.
`timescale 1ns/1ps
interface sarrd_sync_if;
	logic sclk_fall;
	logic sel_fall;
	logic sel_high;
	modport src (output sclk_fall, output sel_fall, output sel_high);
	modport dst (input sclk_fall, input sel_fall, input sel_high);
endinterface

// ==== rtl/sarrd_sync.sv ====
// Two-stage synchroniser and edge finder for select and shift clock.
`timescale 1ns/1ps
module sarrd_sync
	import sarrd_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Pins.
	input  wire logic sel_n_pin,
	input  wire logic sclk_pin,
	// Synchronised levels and edges.
	sarrd_sync_if.src sy
);
	typedef struct packed {
		logic [1:0] sel_meta;
		logic [1:0] sclk_meta;
		logic       sel_d;
		logic       sclk_d;
	} sarrd_sync_st_t;

	sarrd_sync_st_t s_r;
	sarrd_sync_st_t s_nxt;

	always_comb
	begin
		s_nxt           = s_r;
		s_nxt.sel_meta  = {s_r.sel_meta[0], sel_n_pin};
		s_nxt.sclk_meta = {s_r.sclk_meta[0], sclk_pin};
		s_nxt.sel_d     = s_r.sel_meta[1];
		s_nxt.sclk_d    = s_r.sclk_meta[1];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '{sel_meta: 2'h3, sclk_meta: 2'h0, sel_d: 1'b1, sclk_d: 1'b0};
		else
			s_r <= s_nxt;
	end

	assign sy.sel_high  = s_r.sel_meta[1];
	assign sy.sclk_fall = s_r.sclk_d & ~s_r.sclk_meta[1];
	assign sy.sel_fall  = s_r.sel_d & ~s_r.sel_meta[1];
endmodule

// ==== tb/sarrd_host.sv ====
// Host model that frames a conversion and samples the serial data.
`timescale 1ns/1ps
module sarrd_host (
	// Clock.
	input  wire logic clk,
	// Serial link.
	output logic      sel_n,
	output logic      sclk,
	input  wire logic dout,
	input  wire logic oe
);
	logic [31:0] bit_r;
	logic [31:0] oe_r;

	initial
	begin
		sel_n = 1'b1;
		sclk  = 1'b0;
	end

	// The shift clock runs at 800 ns only inside a frame and rests low between frames.
	// Data is sampled just before each falling edge, where it has long settled.
	task automatic frame(input int n);
		bit_r = '0;
		oe_r  = '0;
		@(posedge clk);
		sel_n <= 1'b0;
		for (int i = 1; i <= n + 1; i++)
		begin
			repeat (4) @(posedge clk);
			sclk <= (i <= n);
			repeat (4) @(posedge clk);
			bit_r[i-1] = dout;
			oe_r[i-1]  = oe;
			sclk <= 1'b0;
		end
		sel_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the converter readout sequencer.
`timescale 1ns/1ps
module tb_top;
	import sarrd_pkg::*;
	logic        clk       = 1'b0;
	logic        rst_n     = 1'b0;
	logic        cmp_in    = 1'b0;
	logic [11:0] code      = 12'h000;
	logic        sel_n;
	logic        sclk;
	logic        dout_o;
	logic        dout_oe;
	logic        sample_en;
	logic        conv_done;
	logic [11:0] dac_code;
	logic [11:0] result;
	logic [11:0] v;
	int          err_count  = 0;
	int          num_checks = 0;
	int          cyc        = 0;
	int          n_done     = 0;
	int          n_samp     = 0;

	always #50 clk = ~clk;

	// Comparator of the analog array: high while the input sits at or above the trial code.
	always @(posedge clk)
		cmp_in <= $signed(code) >= $signed(dac_code);

	sarrd_top u_dut (
		.clk                (clk),
		.rst_n              (rst_n),
		.sel_n              (sel_n),
		.serial_shift_clock (sclk),
		.dout_o             (dout_o),
		.dout_oe            (dout_oe),
		.cmp_in             (cmp_in),
		.sample_en          (sample_en),
		.dac_code           (dac_code),
		.conv_done          (conv_done),
		.result             (result)
	);

	sarrd_host u_host (
		.clk   (clk),
		.sel_n (sel_n),
		.sclk  (sclk),
		.dout  (dout_o),
		.oe    (dout_oe)
	);

	always @(posedge clk)
	begin
		cyc++;
		n_done += (conv_done === 1'b1);
		n_samp += (sample_en === 1'b1);
		if (cyc == 5000)
		begin
			err_count++;
			report_and_stop;
		end
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Full frame with two extra clocks after the output has let go.
	task automatic full(input logic [11:0] c);
		@(posedge clk);
		code   <= c;
		n_done = 0;
		n_samp = 0;
		u_host.frame(28);
		chk(12'(u_host.bit_r[2]), 12'h000);
		for (int i = 0; i < 12; i++)
			v[11-i] = u_host.bit_r[3+i];
		chk(v, c);
		for (int i = 0; i < 12; i++)
			v[i] = u_host.bit_r[14+i];
		chk(v, c);
		chk(12'(&u_host.oe_r[25:2]), 12'h001);
		chk(12'(u_host.oe_r[28:26]), 12'h000);
		chk(result, c);
		chk(dac_code, c);
		chk(12'(n_done), 12'h001);
		chk(12'(n_samp >= 12 && n_samp <= 16), 12'h001);
	endtask

	// Right after reset the output is released and the input is not being sampled.
	task automatic after_reset;
		@(posedge clk);
		chk(12'(dout_oe), 12'h000);
		chk(12'(sample_en), 12'h000);
	endtask

	// Select raised right after the last result bit ends the frame early.
	task automatic abort(input logic [11:0] c);
		@(posedge clk);
		code <= c;
		u_host.frame(14);
		chk(12'(u_host.bit_r[14]), 12'(c[0]));
		for (int i = 0; i < 12; i++)
			v[11-i] = u_host.bit_r[3+i];
		chk(v, c);
		chk(result, c);
		chk(12'(dout_oe), 12'h000);
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		after_reset;
		full(CODE_POS_FS);
		full(CODE_ZERO);
		full(CODE_MINUS1);
		full(CODE_NEG_FS);
		full(12'ha5a);
		abort(12'h3c3);
		full(12'h5a5);
		report_and_stop;
	end
endmodule
